// ==== hdl/bsiu_pkg.sv ====
// Package of constants and types for the boundary-scan instruction unit
`default_nettype none
package bsiu_pkg;
  localparam int IR_W = 10;
  localparam int N_PINS = 4;
  localparam int BSR_W = 3 * N_PINS;
  localparam int ID_W = 32;
  // Nine single-bit lines plus the pin levels cross into clk
  localparam int SYNC_W = 9 + N_PINS;
  // Instruction codes
  localparam logic [IR_W-1:0] IR_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] IR_EXTEST = 10'h00f;
  localparam logic [IR_W-1:0] IR_BYPASS = 10'h3ff;
  localparam logic [IR_W-1:0] IR_IDCODE = 10'h006;
  localparam logic [IR_W-1:0] IR_HIGHZ = 10'h00b;
  localparam logic [IR_W-1:0] IR_CLAMP = 10'h00a;
  localparam logic [IR_W-1:0] IR_PULSE_RECONFIG = 10'h001;
  localparam logic [IR_W-1:0] IR_CONFIG_IO = 10'h00d;
  localparam logic [IR_W-1:0] IR_LOCK = 10'h1f0;
  localparam logic [IR_W-1:0] IR_UNLOCK = 10'h331;
  localparam logic [IR_W-1:0] IR_VOLATILE_KEY_CLEAR = 10'h029;
  localparam logic [IR_W-1:0] IR_KEY_VERIFY = 10'h013;
  localparam logic [IR_W-1:0] IR_EXTEST_PULSE = 10'h08f;
  localparam logic [IR_W-1:0] IR_EXTEST_TRAIN = 10'h04f;
  localparam logic [IR_W-1:0] IR_ERROR_REGISTER_SHIFT = 10'h017;
  // Reserved codes that must never reach the active instruction
  localparam logic [IR_W-1:0] IR_PRIV0 = 10'h310;
  localparam logic [IR_W-1:0] IR_PRIV1 = 10'h0c9;
  localparam logic [IR_W-1:0] IR_PRIV2 = 10'h313;
  localparam logic [IR_W-1:0] IR_PRIV3 = 10'h317;
  localparam logic [IR_W-1:0] IR_PRIV4 = 10'h1e0;
  localparam logic [IR_W-1:0] IR_PRIV5 = 10'h3b3;
  localparam logic [IR_W-1:0] IR_PRIV6 = 10'h02a;
  // Leading one then zero, shifted out low bit first
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
  // Identification value is arbitrary; bit 0 is one as the scan standard needs
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0001;
  // Reset values
  localparam logic [IR_W-1:0] IR_RESET = IR_IDCODE;
  localparam logic [BSR_W-1:0] BSR_RESET = 12'h000;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } bsiu_tap_t;
endpackage
`default_nettype wire

// ==== hdl/bsiu_sync.sv ====
// Two-flop synchroniser, one chain per bit
`default_nettype none
module bsiu_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== hdl/bsiu_top.sv ====
// Boundary-scan TAP controller with instruction decode, scan registers and pin control
// Functional notes
// - Clamp code selects bypass and holds pins at update-stage values.
// - Pulse-reconfig code raises an internal reconfig request; pin untouched.
// - I/O-reconfig code accepted only while config status is high.
// - Lock enters secure mode; only six instructions pass then.
// - Lock and unlock accepted only from core-side access in user mode.
// - Unlock leaves secure mode.
// - Volatile-key-clear code pulses the key erase output.
// - Key-verify code shifts out the non-volatile key cleared flag.
// - Extest-pulse inverts output in Run-Test/Idle, true data otherwise, on TCK fall.
// - Extest-train toggles output each TCK fall while in Run-Test/Idle.
// - Extest-pulse and extest-train accepted only in user mode.
// - Tamper protection puts the device in secure mode from reset.
// - Bypass, identification and sample always work, never touching configuration.
// - Chip-wide clear and output enable have no path into this logic.
// - Scan logic runs straight out of reset with no enable.
// - Capture-IR loads one then zero first on TDO in Shift-IR.
// - Zero in the output-enable update cell drives the output-data update cell.
// - Extest refused during reconfiguration unless I/O-reconfig interrupted it.
// - All user pins tri-state while JTAG configuration runs; three cells per pin.
// - Bypass code puts the one-bit bypass register between TDI and TDO.
// - Identification is the active instruction after reset and in Test-Logic-Reset.
// - Extest drives update stage; sample captures pins and preloads update stage.
`default_nettype none
module bsiu_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic core_access,
  input wire logic user_mode,
  input wire logic tamper_protect,
  input wire logic config_status_n,
  input wire logic config_in_progress,
  input wire logic jtag_config_active,
  input wire logic nv_key_cleared,
  input wire logic [bsiu_pkg::N_PINS-1:0] pin_in,
  input wire logic [bsiu_pkg::N_PINS-1:0] core_out,
  input wire logic [bsiu_pkg::N_PINS-1:0] core_oe,
  output logic tdo,
  output logic tdo_oe,
  output logic reconfig_pulse,
  output logic io_config_select,
  output logic volatile_key_clear,
  output logic secure_mode,
  output logic [bsiu_pkg::N_PINS-1:0] pin_out,
  output logic [bsiu_pkg::N_PINS-1:0] pin_oe
);
  logic [bsiu_pkg::SYNC_W-1:0] sync_vec;
  logic tck_s, tms_s, tdi_s, core_s, user_s, status_n_s, busy_s, jcfg_s;
  logic key_done_s;
  logic [bsiu_pkg::N_PINS-1:0] pin_in_s;
  logic tck_q_reg;
  logic tck_rise, tck_fall;
  bsiu_pkg::bsiu_tap_t tap_reg, tap_next;
  logic [bsiu_pkg::IR_W-1:0] ir_sh_reg, act_reg, act_next;
  logic bypass_reg, key_sh_reg, ac_inv_reg, io_int_reg;
  logic [bsiu_pkg::ID_W-1:0] id_sh_reg;
  logic [bsiu_pkg::BSR_W-1:0] bsr_sh_reg, bsr_upd_reg, bsr_cap;
  logic upd_ir_fall, sel_bsr, drive_upd, ac_mode, tdo_next;

  // Pins and the link clock cross into clk here
  bsiu_sync #(.W(bsiu_pkg::SYNC_W)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({pin_in, nv_key_cleared, jtag_config_active, config_in_progress, config_status_n,
               user_mode, core_access, tdi, tms, tck}),
    .sync_out(sync_vec)
  );
  assign {pin_in_s, key_done_s, jcfg_s, busy_s, status_n_s, user_s, core_s, tdi_s, tms_s, tck_s} = sync_vec;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      tck_q_reg <= 1'b0;
    else
      tck_q_reg <= tck_s;
  end
  assign tck_rise = tck_s & ~tck_q_reg;
  assign tck_fall = ~tck_s & tck_q_reg;
  assign upd_ir_fall = tck_fall && (tap_reg == bsiu_pkg::TAP_UPD_IR);

  // TAP state transitions
  always_comb
  begin
    tap_next = tap_reg;
    case (tap_reg)
      bsiu_pkg::TAP_RESET: tap_next = tms_s ? bsiu_pkg::TAP_RESET : bsiu_pkg::TAP_IDLE;
      bsiu_pkg::TAP_IDLE: tap_next = tms_s ? bsiu_pkg::TAP_SEL_DR : bsiu_pkg::TAP_IDLE;
      bsiu_pkg::TAP_SEL_DR: tap_next = tms_s ? bsiu_pkg::TAP_SEL_IR : bsiu_pkg::TAP_CAP_DR;
      bsiu_pkg::TAP_CAP_DR: tap_next = tms_s ? bsiu_pkg::TAP_EX1_DR : bsiu_pkg::TAP_SH_DR;
      bsiu_pkg::TAP_SH_DR: tap_next = tms_s ? bsiu_pkg::TAP_EX1_DR : bsiu_pkg::TAP_SH_DR;
      bsiu_pkg::TAP_EX1_DR: tap_next = tms_s ? bsiu_pkg::TAP_UPD_DR : bsiu_pkg::TAP_PA_DR;
      bsiu_pkg::TAP_PA_DR: tap_next = tms_s ? bsiu_pkg::TAP_EX2_DR : bsiu_pkg::TAP_PA_DR;
      bsiu_pkg::TAP_EX2_DR: tap_next = tms_s ? bsiu_pkg::TAP_UPD_DR : bsiu_pkg::TAP_SH_DR;
      bsiu_pkg::TAP_UPD_DR: tap_next = tms_s ? bsiu_pkg::TAP_SEL_DR : bsiu_pkg::TAP_IDLE;
      bsiu_pkg::TAP_SEL_IR: tap_next = tms_s ? bsiu_pkg::TAP_RESET : bsiu_pkg::TAP_CAP_IR;
      bsiu_pkg::TAP_CAP_IR: tap_next = tms_s ? bsiu_pkg::TAP_EX1_IR : bsiu_pkg::TAP_SH_IR;
      bsiu_pkg::TAP_SH_IR: tap_next = tms_s ? bsiu_pkg::TAP_EX1_IR : bsiu_pkg::TAP_SH_IR;
      bsiu_pkg::TAP_EX1_IR: tap_next = tms_s ? bsiu_pkg::TAP_UPD_IR : bsiu_pkg::TAP_PA_IR;
      bsiu_pkg::TAP_PA_IR: tap_next = tms_s ? bsiu_pkg::TAP_EX2_IR : bsiu_pkg::TAP_PA_IR;
      bsiu_pkg::TAP_EX2_IR: tap_next = tms_s ? bsiu_pkg::TAP_UPD_IR : bsiu_pkg::TAP_SH_IR;
      bsiu_pkg::TAP_UPD_IR: tap_next = tms_s ? bsiu_pkg::TAP_SEL_DR : bsiu_pkg::TAP_IDLE;
      default: tap_next = bsiu_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      tap_reg <= bsiu_pkg::TAP_RESET;
    else if (tck_rise)
      tap_reg <= tap_next;
  end

  // Instruction shift register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ir_sh_reg <= bsiu_pkg::IR_CAPTURE;
    else if (tck_rise && tap_reg == bsiu_pkg::TAP_CAP_IR)
      ir_sh_reg <= bsiu_pkg::IR_CAPTURE;
    else if (tck_rise && tap_reg == bsiu_pkg::TAP_SH_IR)
      ir_sh_reg <= {tdi_s, ir_sh_reg[bsiu_pkg::IR_W-1:1]};
  end

  // Decide which instruction becomes active; refused codes fall back to bypass
  always_comb
  begin
    act_next = ir_sh_reg;
    case (ir_sh_reg)
      bsiu_pkg::IR_LOCK, bsiu_pkg::IR_UNLOCK:
        if (!(core_s && user_s))
          act_next = bsiu_pkg::IR_BYPASS;
      bsiu_pkg::IR_EXTEST_PULSE, bsiu_pkg::IR_EXTEST_TRAIN:
        if (!user_s || (busy_s && !io_int_reg))
          act_next = bsiu_pkg::IR_BYPASS;
      bsiu_pkg::IR_EXTEST:
        if (busy_s && !io_int_reg)
          act_next = bsiu_pkg::IR_BYPASS;
      bsiu_pkg::IR_CONFIG_IO:
        if (status_n_s == 1'b0)
          act_next = bsiu_pkg::IR_BYPASS;
      bsiu_pkg::IR_PRIV0, bsiu_pkg::IR_PRIV1, bsiu_pkg::IR_PRIV2, bsiu_pkg::IR_PRIV3,
      bsiu_pkg::IR_PRIV4, bsiu_pkg::IR_PRIV5, bsiu_pkg::IR_PRIV6:
        act_next = bsiu_pkg::IR_BYPASS;
      default: act_next = ir_sh_reg;
    endcase
    if (secure_mode)
    begin
      case (ir_sh_reg)
        bsiu_pkg::IR_BYPASS, bsiu_pkg::IR_SAMPLE, bsiu_pkg::IR_EXTEST, bsiu_pkg::IR_IDCODE,
        bsiu_pkg::IR_ERROR_REGISTER_SHIFT, bsiu_pkg::IR_UNLOCK: act_next = act_next;
        default: act_next = bsiu_pkg::IR_BYPASS;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      act_reg <= bsiu_pkg::IR_RESET;
    else if (tap_reg == bsiu_pkg::TAP_RESET)
      act_reg <= bsiu_pkg::IR_IDCODE;
    else if (upd_ir_fall)
      act_reg <= act_next;
  end

  // Secure mode: tamper setting is taken during reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      secure_mode <= tamper_protect;
    else if (upd_ir_fall && act_next == bsiu_pkg::IR_LOCK && ir_sh_reg == bsiu_pkg::IR_LOCK)
      secure_mode <= 1'b1;
    else if (upd_ir_fall && act_next == bsiu_pkg::IR_UNLOCK && ir_sh_reg == bsiu_pkg::IR_UNLOCK)
      secure_mode <= 1'b0;
  end

  // One-cycle requests to configuration and key logic
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      reconfig_pulse <= 1'b0;
      volatile_key_clear <= 1'b0;
    end
    else
    begin
      reconfig_pulse <= upd_ir_fall && act_next == bsiu_pkg::IR_PULSE_RECONFIG;
      volatile_key_clear <= upd_ir_fall && act_next == bsiu_pkg::IR_VOLATILE_KEY_CLEAR;
    end
  end

  // Remembers that I/O-reconfig interrupted configuration until a reconfig request
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      io_int_reg <= 1'b0;
    else if (reconfig_pulse)
      io_int_reg <= 1'b0;
    else if (upd_ir_fall && act_next == bsiu_pkg::IR_CONFIG_IO)
      io_int_reg <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      io_config_select <= 1'b0;
    else
      io_config_select <= (act_reg == bsiu_pkg::IR_CONFIG_IO);
  end

  // Capture pattern per pin: output data, output enable, pin level
  genvar p;
  generate
    for (p = 0; p < bsiu_pkg::N_PINS; p++)
    begin : g_cap
      assign bsr_cap[3*p+2:3*p] = {pin_in_s[p], core_oe[p], core_out[p]};
    end
  endgenerate

  assign sel_bsr = (act_reg == bsiu_pkg::IR_SAMPLE) || (act_reg == bsiu_pkg::IR_EXTEST) ||
                   (act_reg == bsiu_pkg::IR_EXTEST_PULSE) || (act_reg == bsiu_pkg::IR_EXTEST_TRAIN);

  // Data registers capture and shift on TCK rise
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bypass_reg <= 1'b0;
      key_sh_reg <= 1'b0;
      id_sh_reg <= bsiu_pkg::ID_VALUE;
      bsr_sh_reg <= bsiu_pkg::BSR_RESET;
    end
    else if (tck_rise && tap_reg == bsiu_pkg::TAP_CAP_DR)
    begin
      bypass_reg <= 1'b0;
      key_sh_reg <= key_done_s;
      id_sh_reg <= bsiu_pkg::ID_VALUE;
      if (sel_bsr)
        bsr_sh_reg <= bsr_cap;
    end
    else if (tck_rise && tap_reg == bsiu_pkg::TAP_SH_DR)
    begin
      bypass_reg <= tdi_s;
      key_sh_reg <= tdi_s;
      id_sh_reg <= {tdi_s, id_sh_reg[bsiu_pkg::ID_W-1:1]};
      if (sel_bsr)
        bsr_sh_reg <= {tdi_s, bsr_sh_reg[bsiu_pkg::BSR_W-1:1]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      bsr_upd_reg <= bsiu_pkg::BSR_RESET;
    else if (tck_fall && tap_reg == bsiu_pkg::TAP_UPD_DR && sel_bsr)
      bsr_upd_reg <= bsr_sh_reg;
  end

  // TDO source selection; bypass covers clamp, highz and unknown codes
  always_comb
  begin
    tdo_next = bypass_reg;
    if (tap_reg == bsiu_pkg::TAP_SH_IR)
      tdo_next = ir_sh_reg[0];
    else if (act_reg == bsiu_pkg::IR_IDCODE)
      tdo_next = id_sh_reg[0];
    else if (act_reg == bsiu_pkg::IR_KEY_VERIFY)
      tdo_next = key_sh_reg;
    else if (sel_bsr)
      tdo_next = bsr_sh_reg[0];
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo <= tdo_next;
      tdo_oe <= (tap_reg == bsiu_pkg::TAP_SH_IR) || (tap_reg == bsiu_pkg::TAP_SH_DR);
    end
  end

  // AC test inversion, changed on TCK fall
  assign ac_mode = (act_reg == bsiu_pkg::IR_EXTEST_PULSE) || (act_reg == bsiu_pkg::IR_EXTEST_TRAIN);
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ac_inv_reg <= 1'b0;
    else if (!ac_mode || tap_reg != bsiu_pkg::TAP_IDLE)
    begin
      if (tck_fall)
        ac_inv_reg <= 1'b0;
    end
    else if (tck_fall && act_reg == bsiu_pkg::IR_EXTEST_TRAIN)
      ac_inv_reg <= ~ac_inv_reg;
    else if (tck_fall)
      ac_inv_reg <= 1'b1;
  end

  // Pin drive: chip-wide clear and output enable have no input here at all
  assign drive_upd = sel_bsr && (act_reg != bsiu_pkg::IR_SAMPLE);
  generate
    for (p = 0; p < bsiu_pkg::N_PINS; p++)
    begin : g_pin
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          pin_out[p] <= 1'b0;
          pin_oe[p] <= 1'b0;
        end
        else if (jcfg_s || act_reg == bsiu_pkg::IR_HIGHZ)
        begin
          pin_out[p] <= 1'b0;
          pin_oe[p] <= 1'b0;
        end
        else if (drive_upd || act_reg == bsiu_pkg::IR_CLAMP)
        begin
          pin_out[p] <= bsr_upd_reg[3*p] ^ (ac_mode & ac_inv_reg);
          pin_oe[p] <= ~bsr_upd_reg[3*p+1];
        end
        else
        begin
          pin_out[p] <= core_out[p];
          pin_oe[p] <= core_oe[p];
        end
      end
    end
  endgenerate

  property p_reconfig_single;
    @(posedge clk) disable iff (!reset_n)
    reconfig_pulse |=> !reconfig_pulse;
  endproperty
  a_reconfig_single: assert property (p_reconfig_single) else $error("reconfig pulse too long");

  property p_lock_external;
    @(posedge clk) disable iff (!reset_n)
    (upd_ir_fall && ir_sh_reg == bsiu_pkg::IR_LOCK && !core_s) |=> secure_mode == $past(secure_mode);
  endproperty
  a_lock_external: assert property (p_lock_external) else $error("external lock changed secure mode");

  property p_unlock;
    @(posedge clk) disable iff (!reset_n)
    (upd_ir_fall && ir_sh_reg == bsiu_pkg::IR_UNLOCK && core_s && user_s) |=> !secure_mode;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock did not release secure mode");

  property p_secure_refuse;
    @(posedge clk) disable iff (!reset_n)
    (secure_mode && upd_ir_fall && ir_sh_reg == bsiu_pkg::IR_HIGHZ) |=> act_reg == bsiu_pkg::IR_BYPASS;
  endproperty
  a_secure_refuse: assert property (p_secure_refuse) else $error("secure mode accepted blocked code");

  property p_reset_idcode;
    @(posedge clk) disable iff (!reset_n)
    (tap_reg == bsiu_pkg::TAP_RESET) |=> act_reg == bsiu_pkg::IR_IDCODE;
  endproperty
  a_reset_idcode: assert property (p_reset_idcode) else $error("idcode not active in reset state");

  property p_ir_capture;
    @(posedge clk) disable iff (!reset_n)
    (tck_rise && tap_reg == bsiu_pkg::TAP_CAP_IR) |=> ir_sh_reg[1:0] == 2'h1;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("capture-ir pattern wrong");

  property p_train_toggle;
    @(posedge clk) disable iff (!reset_n)
    (tck_fall && act_reg == bsiu_pkg::IR_EXTEST_TRAIN && tap_reg == bsiu_pkg::TAP_IDLE)
      |=> ac_inv_reg != $past(ac_inv_reg);
  endproperty
  a_train_toggle: assert property (p_train_toggle) else $error("train did not toggle");

  property p_pulse_restore;
    @(posedge clk) disable iff (!reset_n)
    (tck_fall && tap_reg != bsiu_pkg::TAP_IDLE) |=> !ac_inv_reg;
  endproperty
  a_pulse_restore: assert property (p_pulse_restore) else $error("inversion held outside idle");

  property p_config_tristate;
    @(posedge clk) disable iff (!reset_n)
    jcfg_s |=> pin_oe == '0;
  endproperty
  a_config_tristate: assert property (p_config_tristate) else $error("pins driven during jtag config");

  property p_ac_user_only;
    @(posedge clk) disable iff (!reset_n)
    (!user_s && upd_ir_fall && ir_sh_reg == bsiu_pkg::IR_EXTEST_PULSE) |=> act_reg == bsiu_pkg::IR_BYPASS;
  endproperty
  a_ac_user_only: assert property (p_ac_user_only) else $error("ac test accepted outside user mode");
endmodule
`default_nettype wire

// ==== verification/bsiu_jtag_host.sv ====
// JTAG host model that drives the scan link of the instruction unit
`default_nettype none
module bsiu_jtag_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime HALF = 62.5ns;
  // Clock rests low and pulled-up lines rest high between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One TCK cycle; TDO is taken just before the rising edge
  task automatic clock(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #HALF;
    q = tdo;
    tck = 1'b1;
    #HALF;
    tck = 1'b0;
  endtask
  // Shift n bits low first, then Exit1, Update and park in Idle
  task automatic shift(input int n, input logic [31:0] d, output logic [31:0] q);
    logic b;
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      clock(i == n - 1, d[i], b);
      q[i] = b;
    end
    clock(1'b1, 1'b1, b);
    clock(1'b0, 1'b1, b);
    tms = 1'b1;
    tdi = 1'b1;
  endtask
  task automatic reset_tap();
    logic b;
    repeat (5) clock(1'b1, 1'b1, b);
    tms = 1'b1;
  endtask
  // Entered in Select-DR
  task automatic ir_from_sel(input logic [9:0] c, output logic [9:0] cap);
    logic b;
    logic [31:0] q;
    clock(1'b1, 1'b1, b);
    clock(1'b0, 1'b1, b);
    clock(1'b0, 1'b1, b);
    shift(10, {22'h0, c}, q);
    cap = q[9:0];
  endtask
  // Entered in Test-Logic-Reset or Idle
  task automatic load_ir(input logic [9:0] c, output logic [9:0] cap);
    logic b;
    clock(1'b0, 1'b1, b);
    clock(1'b1, 1'b1, b);
    ir_from_sel(c, cap);
  endtask
  task automatic scan_dr(input int n, input logic [31:0] d, output logic [31:0] q);
    logic b;
    clock(1'b0, 1'b1, b);
    clock(1'b1, 1'b1, b);
    clock(1'b0, 1'b1, b);
    clock(1'b0, 1'b1, b);
    shift(n, d, q);
  endtask
endmodule
`default_nettype wire

// ==== verification/bsiu_top_test.sv ====
// Self-checking bench for the boundary-scan instruction unit
`default_nettype none
module bsiu_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  wire tck;
  wire tms;
  wire tdi;
  logic core_access = 1'b0;
  logic user_mode = 1'b0;
  logic tamper_protect = 1'b0;
  logic config_status_n = 1'b1;
  logic config_in_progress = 1'b0;
  logic jtag_config_active = 1'b0;
  logic nv_key_cleared = 1'b0;
  logic [3:0] pin_in = 4'h9;
  logic [3:0] core_out = 4'h5;
  logic [3:0] core_oe = 4'h3;
  logic tdo;
  logic tdo_oe;
  logic reconfig_pulse;
  logic io_config_select;
  logic volatile_key_clear;
  logic secure_mode;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  int miscompares = 0;
  int n_checks = 0;
  int n_rc = 0;
  int n_kc = 0;
  int n_oe = 0;
  logic [31:0] q;
  logic [9:0] cap;
  logic b;
  always #4 clk = ~clk;
  bsiu_top bsiu_top_inst (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .core_access(core_access), .user_mode(user_mode), .tamper_protect(tamper_protect),
    .config_status_n(config_status_n), .config_in_progress(config_in_progress),
    .jtag_config_active(jtag_config_active), .nv_key_cleared(nv_key_cleared), .pin_in(pin_in),
    .core_out(core_out), .core_oe(core_oe), .tdo(tdo), .tdo_oe(tdo_oe), .reconfig_pulse(reconfig_pulse),
    .io_config_select(io_config_select), .volatile_key_clear(volatile_key_clear),
    .secure_mode(secure_mode), .pin_out(pin_out), .pin_oe(pin_oe));
  bsiu_jtag_host bsiu_jtag_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // Pulse counters: a stuck strobe shows as an excess count
  always @(posedge clk)
  begin
    n_rc <= n_rc + int'(reconfig_pulse === 1'b1);
    n_kc <= n_kc + int'(volatile_key_clear === 1'b1);
    n_oe <= n_oe + int'(tdo_oe === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic ir(input logic [9:0] c);
    bsiu_jtag_host_inst.load_ir(c, cap);
    settle();
  endtask
  task automatic do_reset();
    @(posedge clk) reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    settle();
  endtask
  task automatic t_reset_id();
    chk(secure_mode, 1'b0);
    bsiu_jtag_host_inst.scan_dr(32, 32'h0, q);
    chk(q, bsiu_pkg::ID_VALUE);
    bsiu_jtag_host_inst.load_ir(bsiu_pkg::IR_BYPASS, cap);
    chk(cap, 10'h001);
    bsiu_jtag_host_inst.scan_dr(4, 32'hb, q);
    chk(q, 32'h6);
    settle();
    chk(tdo_oe, 1'b0);
    chk(int'(n_oe > 0), 1);
    $display("done reset and identification");
  endtask
  task automatic t_boundary();
    ir(bsiu_pkg::IR_SAMPLE);
    chk(pin_out, core_out);
    bsiu_jtag_host_inst.scan_dr(12, 32'h448, q);
    chk({q[11], q[8], q[5], q[2]}, pin_in);
    ir(bsiu_pkg::IR_EXTEST);
    chk(pin_out, 4'h6);
    chk(pin_oe, 4'h7);
    ir(bsiu_pkg::IR_CLAMP);
    chk({pin_oe, pin_out}, 8'h76);
    @(posedge clk) jtag_config_active <= 1'b1;
    settle();
    chk(pin_oe, 4'h0);
    @(posedge clk) jtag_config_active <= 1'b0;
    ir(bsiu_pkg::IR_EXTEST_PULSE);
    chk(pin_out, core_out);
    @(posedge clk) user_mode <= 1'b1;
    config_in_progress <= 1'b1;
    ir(bsiu_pkg::IR_EXTEST);
    chk(pin_out, core_out);
    @(posedge clk) config_in_progress <= 1'b0;
    $display("done boundary cells");
  endtask
  task automatic t_pulse();
    ir(bsiu_pkg::IR_EXTEST_PULSE);
    chk(pin_out, 4'h9);
    bsiu_jtag_host_inst.clock(1'b0, 1'b1, b);
    settle();
    chk(pin_out, 4'h9);
    bsiu_jtag_host_inst.clock(1'b1, 1'b1, b);
    settle();
    chk(pin_out, 4'h6);
    bsiu_jtag_host_inst.ir_from_sel(bsiu_pkg::IR_EXTEST_TRAIN, cap);
    settle();
    chk(pin_out, 4'h9);
    bsiu_jtag_host_inst.clock(1'b0, 1'b1, b);
    settle();
    chk(pin_out, 4'h6);
    bsiu_jtag_host_inst.clock(1'b0, 1'b1, b);
    settle();
    chk(pin_out, 4'h9);
    bsiu_jtag_host_inst.reset_tap();
    $display("done pulse and train");
  endtask
  task automatic t_cmds();
    ir(bsiu_pkg::IR_PULSE_RECONFIG);
    chk(n_rc, 1);
    ir(bsiu_pkg::IR_VOLATILE_KEY_CLEAR);
    chk(n_kc, 1);
    @(posedge clk) nv_key_cleared <= 1'b1;
    ir(bsiu_pkg::IR_KEY_VERIFY);
    bsiu_jtag_host_inst.scan_dr(1, 32'h0, q);
    chk(q, 32'h1);
    @(posedge clk) nv_key_cleared <= 1'b0;
    bsiu_jtag_host_inst.scan_dr(1, 32'h1, q);
    chk(q, 32'h0);
    @(posedge clk) config_status_n <= 1'b0;
    ir(bsiu_pkg::IR_CONFIG_IO);
    chk(io_config_select, 1'b0);
    @(posedge clk) config_status_n <= 1'b1;
    ir(bsiu_pkg::IR_CONFIG_IO);
    chk(io_config_select, 1'b1);
    @(posedge clk) config_in_progress <= 1'b1;
    ir(bsiu_pkg::IR_EXTEST);
    chk(pin_out, 4'h6);
    ir(bsiu_pkg::IR_PULSE_RECONFIG);
    chk(n_rc, 2);
    ir(bsiu_pkg::IR_EXTEST);
    chk(pin_out, core_out);
    @(posedge clk) config_in_progress <= 1'b0;
    $display("done commands");
  endtask
  task automatic t_lock();
    ir(bsiu_pkg::IR_LOCK);
    chk(secure_mode, 1'b0);
    @(posedge clk) core_access <= 1'b1;
    ir(bsiu_pkg::IR_LOCK);
    chk(secure_mode, 1'b1);
    ir(bsiu_pkg::IR_HIGHZ);
    chk(pin_oe, core_oe);
    ir(bsiu_pkg::IR_PULSE_RECONFIG);
    chk(n_rc, 2);
    @(posedge clk) core_access <= 1'b0;
    ir(bsiu_pkg::IR_UNLOCK);
    chk(secure_mode, 1'b1);
    @(posedge clk) core_access <= 1'b1;
    ir(bsiu_pkg::IR_UNLOCK);
    chk(secure_mode, 1'b0);
    @(posedge clk) tamper_protect <= 1'b1;
    do_reset();
    chk(secure_mode, 1'b1);
    $display("done secure mode");
  endtask
  initial
  begin
    do_reset();
    t_reset_id();
    t_boundary();
    t_pulse();
    t_cmds();
    t_lock();
    summarize();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
